//--- inc/hpl_pkg.sv
// shared constants and types of the slot indicator and latch block
package hpl_pkg;

   // bus geometry and answers
   localparam int unsigned ADDR_W      = 8;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // register byte offsets
   localparam logic [7:0]  CTRL_OFS    = 8'h00;
   localparam logic [7:0]  STAT_OFS    = 8'h04;

   // control register fields
   localparam int unsigned CTRL_ATTN_LSB = 0;
   localparam int unsigned CTRL_PWR_LSB  = 2;
   localparam int unsigned CTRL_MPWR_BIT = 4;

   // status register fields
   localparam int unsigned STAT_LATCH_BIT = 0;
   localparam int unsigned STAT_MAIN_BIT  = 1;
   localparam int unsigned STAT_AUX_BIT   = 2;
   localparam int unsigned STAT_ATTN_BIT  = 3;
   localparam int unsigned STAT_PLED_BIT  = 4;
   localparam int unsigned STAT_STUCK_BIT = 5;

   typedef enum logic [1:0] {
      IND_OFF   = 2'h0,
      IND_ON    = 2'h1,
      IND_BLINK = 2'h2
   } hpl_ind_mode_t;

   typedef enum logic {
      WR_IDLE = 1'b0,
      WR_RESP = 1'b1
   } hpl_wr_state_t;

   typedef enum logic {
      RD_IDLE = 1'b0,
      RD_DATA = 1'b1
   } hpl_rd_state_t;

   // reset values
   localparam hpl_ind_mode_t ATTN_RST = IND_OFF;
   localparam hpl_ind_mode_t PWR_RST  = IND_OFF;
   localparam logic          MPWR_RST = 1'b0;

   // timing: clock period, blink half period, latch settle time
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned BLINK_HALF_MS  = 333;
   localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned DEBOUNCE_MS    = 10;
   localparam int unsigned DEBOUNCE_CYC   = (DEBOUNCE_MS * 1000000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;

endpackage : hpl_pkg

//--- inc/hpl_latch_if.sv
// latch sensor path between the top and its filter
`timescale 1ns/1ps
interface hpl_latch_if;
   logic raw_closed;
   logic clean_closed;

   modport filt (input raw_closed, output clean_closed);
   modport user (output raw_closed, input clean_closed);
endinterface : hpl_latch_if

//--- hdl/hpl_latch_filter.sv
// retention latch sensor synchroniser and bounce filter
`timescale 1ns/1ps
module hpl_latch_filter #(
   parameter int unsigned DEBOUNCE_CYC = hpl_pkg::DEBOUNCE_CYC
) (
   input  wire logic   clk,
   input  wire logic   rst,
   input  wire logic   ce,
   hpl_latch_if.filt   lif
);

   logic        meta_q;
   logic        sync_q;
   logic [31:0] stab_q;
   logic        clean_q;

   // two flops; only sync_q is looked at further on
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else if (ce) begin
         meta_q <= lif.raw_closed;
         sync_q <= meta_q;
      end
   end

   // count how long the sensor has said closed
   always_ff @(posedge clk) begin
      if (rst) begin
         stab_q <= 32'h0;
      end else if (ce) begin
         if (!sync_q) begin
            stab_q <= 32'h0;
         end else if (stab_q != 32'(DEBOUNCE_CYC - 1)) begin
            stab_q <= stab_q + 32'h1;
         end
      end
   end

   // open wins at once, closed only after a quiet spell: bounce can never power up
   always_ff @(posedge clk) begin
      if (rst) begin
         clean_q <= 1'b0;
      end else if (ce) begin
         if (!sync_q) begin
            clean_q <= 1'b0; // see RQ7
         end else if (stab_q == 32'(DEBOUNCE_CYC - 1)) begin
            clean_q <= 1'b1; // see RQ13
         end
      end
   end

   assign lif.clean_closed = clean_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);

   chk_open_fast: assert property (!sync_q |=> !clean_q) // see RQ7
      else $error("filtered latch stayed closed after sensor opened");

   chk_close_settled: assert property ($rose(clean_q) // see RQ13
      |-> $past(stab_q) == 32'(DEBOUNCE_CYC - 1) && $past(sync_q))
      else $error("filtered latch closed before the sensor settled");

endmodule : hpl_latch_filter

//--- hdl/hpl_top.sv
// slot indicators, latch handling and register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

// Contract
// RQ1: attention indicator has off, on and blinking (locate) states.
// RQ2: software does not light attention for pre-acceptance validation failures.
// RQ3: software requests attention blinking only on a user's behalf.
// RQ4: power indicator has off, on and blinking (transition) states.
// RQ5: software sets power indicator off when unpowered or removal allowed.
// RQ6: software blinks power indicator as operator feedback on accepted requests.
// RQ7: latch counts as closed only when fully closed; otherwise open.
// RQ8: with a power controller, main power drops at once when latch opens.
// RQ9: latch-switched aux and sideband drop on open, return on close (only AUX_SW_EN does so here; there is no sideband output).
// RQ10: latch changes never alter either indicator state.
// RQ11: blinking runs between 1 and 2 Hz with 50 percent duty.
// RQ12: indicators change only on command; stuck-on fault may force power on.
// RQ13: latch sensor is synchronised and debounced before use.
module hpl_top #(
   parameter int unsigned BLINK_HALF_CYC = hpl_pkg::BLINK_HALF_CYC,
   parameter int unsigned DEBOUNCE_CYC   = hpl_pkg::DEBOUNCE_CYC,
   parameter bit          HAS_PWR_CTRL   = 1'b1
) (
   input  wire logic                       REF_CLK,
   input  wire logic                       SRST,
   input  wire logic                       CE,
   input  wire logic [hpl_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                       S_AXI_AWVALID,
   output wire logic                       S_AXI_AWREADY,
   input  wire logic [31:0]                S_AXI_WDATA,
   input  wire logic [3:0]                 S_AXI_WSTRB,
   input  wire logic                       S_AXI_WVALID,
   output wire logic                       S_AXI_WREADY,
   output wire logic [1:0]                 S_AXI_BRESP,
   output wire logic                       S_AXI_BVALID,
   input  wire logic                       S_AXI_BREADY,
   input  wire logic [hpl_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic                       S_AXI_ARVALID,
   output wire logic                       S_AXI_ARREADY,
   output wire logic [31:0]                S_AXI_RDATA,
   output wire logic [1:0]                 S_AXI_RRESP,
   output wire logic                       S_AXI_RVALID,
   input  wire logic                       S_AXI_RREADY,
   input  wire logic                       LATCH_CLOSED,
   input  wire logic                       PWR_STUCK_ON,
   output wire logic                       ATTN_LED,
   output wire logic                       PWR_LED,
   output wire logic                       MAIN_PWR_EN,
   output wire logic                       AUX_SW_EN
);

   // word decode shared by both channels
   function automatic logic is_ctrl(input logic [hpl_pkg::ADDR_W-1:0] a);
      return a[hpl_pkg::ADDR_W-1:2] == hpl_pkg::CTRL_OFS[hpl_pkg::ADDR_W-1:2];
   endfunction : is_ctrl

   function automatic logic is_stat(input logic [hpl_pkg::ADDR_W-1:0] a);
      return a[hpl_pkg::ADDR_W-1:2] == hpl_pkg::STAT_OFS[hpl_pkg::ADDR_W-1:2];
   endfunction : is_stat

   // indicator drive from mode and blink phase; reserved code shows dark
   function automatic logic led_drive(input hpl_pkg::hpl_ind_mode_t m, input logic ph);
      logic v;
      v = 1'b0;
      unique case (m)
         hpl_pkg::IND_OFF:   v = 1'b0;
         hpl_pkg::IND_ON:    v = 1'b1;
         hpl_pkg::IND_BLINK: v = ph;
         default:            v = 1'b0;
      endcase
      return v;
   endfunction : led_drive

   hpl_pkg::hpl_wr_state_t       wr_q;
   hpl_pkg::hpl_rd_state_t       rd_q;
   logic                         aw_got_q;
   logic                         w_got_q;
   logic [hpl_pkg::ADDR_W-1:0]   aw_addr_q;
   logic [31:0]                  w_data_q;
   logic                         w_strb0_q;
   logic [1:0]                   bresp_q;
   logic [31:0]                  rdata_q;
   logic [1:0]                   rresp_q;
   hpl_pkg::hpl_ind_mode_t       attn_mode_q;
   hpl_pkg::hpl_ind_mode_t       pwr_mode_q;
   logic                         mpwr_req_q;
   logic                         main_pwr_q;
   logic                         aux_q;
   logic [31:0]                  blink_cnt_q;
   logic                         blink_phase_q;
   logic                         attn_led_q;
   logic                         pwr_led_q;
   logic                         latch_ok;
   logic                         aw_fire;
   logic                         w_fire;
   logic                         ar_fire;
   logic                         wr_do;
   logic                         ctrl_wr;
   logic [hpl_pkg::ADDR_W-1:0]   addr_eff;
   logic [31:0]                  data_eff;
   logic                         strb0_eff;
   logic [31:0]                  stat_word;
   logic [31:0]                  ctrl_word;

   hpl_latch_if lat_if ();

   assign lat_if.raw_closed = LATCH_CLOSED;
   assign latch_ok          = lat_if.clean_closed;

   hpl_latch_filter #(
      .DEBOUNCE_CYC (DEBOUNCE_CYC)
   ) u_filter (
      .clk (REF_CLK),
      .rst (SRST),
      .ce  (CE),
      .lif (lat_if)
   );

   // ---- write channel: address and data taken in either order
   assign S_AXI_AWREADY = CE && (wr_q == hpl_pkg::WR_IDLE) && !aw_got_q;
   assign S_AXI_WREADY  = CE && (wr_q == hpl_pkg::WR_IDLE) && !w_got_q;
   assign aw_fire       = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_fire        = S_AXI_WVALID && S_AXI_WREADY;

   always_comb begin
      addr_eff  = aw_got_q ? aw_addr_q : S_AXI_AWADDR;
      data_eff  = w_got_q ? w_data_q : S_AXI_WDATA;
      strb0_eff = w_got_q ? w_strb0_q : S_AXI_WSTRB[0];
      wr_do     = CE && (wr_q == hpl_pkg::WR_IDLE) && (aw_got_q || aw_fire)
                  && (w_got_q || w_fire);
      ctrl_wr   = wr_do && is_ctrl(addr_eff) && strb0_eff;
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         aw_got_q  <= 1'b0;
         aw_addr_q <= '0;
      end else if (CE) begin
         if (wr_do) begin
            aw_got_q <= 1'b0;
         end else if (aw_fire) begin
            aw_got_q  <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         w_got_q   <= 1'b0;
         w_data_q  <= 32'h0;
         w_strb0_q <= 1'b0;
      end else if (CE) begin
         if (wr_do) begin
            w_got_q <= 1'b0;
         end else if (w_fire) begin
            w_got_q   <= 1'b1;
            w_data_q  <= S_AXI_WDATA;
            w_strb0_q <= S_AXI_WSTRB[0];
         end
      end
   end

   // status is read-only: a write there is accepted and dropped
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         wr_q    <= hpl_pkg::WR_IDLE;
         bresp_q <= hpl_pkg::RESP_OKAY;
      end else if (CE) begin
         unique case (wr_q)
            hpl_pkg::WR_IDLE: begin
               if (wr_do) begin
                  wr_q    <= hpl_pkg::WR_RESP;
                  bresp_q <= (is_ctrl(addr_eff) || is_stat(addr_eff)) ?
                             hpl_pkg::RESP_OKAY : hpl_pkg::RESP_SLVERR;
               end
            end
            hpl_pkg::WR_RESP: begin
               if (S_AXI_BREADY) begin
                  wr_q <= hpl_pkg::WR_IDLE;
               end
            end
         endcase
      end
   end

   assign S_AXI_BVALID = (wr_q == hpl_pkg::WR_RESP);
   assign S_AXI_BRESP  = bresp_q;

   // ---- read channel
   assign S_AXI_ARREADY = CE && (rd_q == hpl_pkg::RD_IDLE);
   assign ar_fire       = S_AXI_ARVALID && S_AXI_ARREADY;

   always_comb begin
      ctrl_word = 32'h0;
      ctrl_word[hpl_pkg::CTRL_ATTN_LSB +: 2] = attn_mode_q;
      ctrl_word[hpl_pkg::CTRL_PWR_LSB +: 2]  = pwr_mode_q;
      ctrl_word[hpl_pkg::CTRL_MPWR_BIT]      = mpwr_req_q;
      stat_word = 32'h0;
      stat_word[hpl_pkg::STAT_LATCH_BIT] = latch_ok;
      stat_word[hpl_pkg::STAT_MAIN_BIT]  = main_pwr_q;
      stat_word[hpl_pkg::STAT_AUX_BIT]   = aux_q;
      stat_word[hpl_pkg::STAT_ATTN_BIT]  = attn_led_q;
      stat_word[hpl_pkg::STAT_PLED_BIT]  = pwr_led_q;
      stat_word[hpl_pkg::STAT_STUCK_BIT] = PWR_STUCK_ON;
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         rd_q    <= hpl_pkg::RD_IDLE;
         rdata_q <= 32'h0;
         rresp_q <= hpl_pkg::RESP_OKAY;
      end else if (CE) begin
         unique case (rd_q)
            hpl_pkg::RD_IDLE: begin
               if (ar_fire) begin
                  rd_q <= hpl_pkg::RD_DATA;
                  if (is_ctrl(S_AXI_ARADDR)) begin
                     rdata_q <= ctrl_word;
                     rresp_q <= hpl_pkg::RESP_OKAY;
                  end else if (is_stat(S_AXI_ARADDR)) begin
                     rdata_q <= stat_word;
                     rresp_q <= hpl_pkg::RESP_OKAY;
                  end else begin
                     rdata_q <= 32'h0;
                     rresp_q <= hpl_pkg::RESP_SLVERR;
                  end
               end
            end
            hpl_pkg::RD_DATA: begin
               if (S_AXI_RREADY) begin
                  rd_q <= hpl_pkg::RD_IDLE;
               end
            end
         endcase
      end
   end

   assign S_AXI_RVALID = (rd_q == hpl_pkg::RD_DATA);
   assign S_AXI_RDATA  = rdata_q;
   assign S_AXI_RRESP  = rresp_q;

   // ---- indicator commands: only a software write moves them
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         attn_mode_q <= hpl_pkg::ATTN_RST;
         pwr_mode_q  <= hpl_pkg::PWR_RST;
      end else if (CE && ctrl_wr) begin
         attn_mode_q <= hpl_pkg::hpl_ind_mode_t'(data_eff[hpl_pkg::CTRL_ATTN_LSB +: 2]); // see RQ1
         pwr_mode_q  <= hpl_pkg::hpl_ind_mode_t'(data_eff[hpl_pkg::CTRL_PWR_LSB +: 2]); // see RQ4
      end
   end

   // ---- blink timebase, free running so both lamps blink in step
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         blink_cnt_q   <= 32'h0;
         blink_phase_q <= 1'b0;
      end else if (CE) begin
         if (blink_cnt_q == 32'(BLINK_HALF_CYC - 1)) begin
            blink_cnt_q   <= 32'h0;
            blink_phase_q <= ~blink_phase_q; // see RQ11
         end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
         end
      end
   end

   // latch state is deliberately absent here
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         attn_led_q <= 1'b0;
         pwr_led_q  <= 1'b0;
      end else if (CE) begin
         attn_led_q <= led_drive(attn_mode_q, blink_phase_q); // see RQ1, RQ10
         pwr_led_q  <= PWR_STUCK_ON || led_drive(pwr_mode_q, blink_phase_q); // see RQ12
      end
   end

   // ---- slot power: latch open beats a same-cycle power-on write
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         mpwr_req_q <= hpl_pkg::MPWR_RST;
         main_pwr_q <= 1'b0;
      end else if (CE) begin
         if (ctrl_wr) begin
            mpwr_req_q <= data_eff[hpl_pkg::CTRL_MPWR_BIT];
         end
         if (HAS_PWR_CTRL && !latch_ok) begin
            main_pwr_q <= 1'b0; // see RQ8
         end else if (ctrl_wr) begin
            main_pwr_q <= data_eff[hpl_pkg::CTRL_MPWR_BIT];
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         aux_q <= 1'b0;
      end else if (CE) begin
         aux_q <= latch_ok; // see RQ9
      end
   end

   assign ATTN_LED    = attn_led_q;
   assign PWR_LED     = pwr_led_q;
   assign MAIN_PWR_EN = main_pwr_q;
   assign AUX_SW_EN   = aux_q;

   // ---- checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SRST || !CE);

   sequence latch_drop_s;
      $fell(latch_ok);
   endsequence

   sequence power_gone_s;
      !main_pwr_q [*2];
   endsequence

   chk_main_power_cut: assert property ((HAS_PWR_CTRL and latch_drop_s) |=> power_gone_s) // see RQ8
      else $error("main power not removed when latch opened");

   chk_aux_follow: assert property (##1 aux_q == $past(latch_ok)) // see RQ9
      else $error("switched aux does not follow the latch");

   chk_attn_states: assert property (attn_mode_q != hpl_pkg::IND_BLINK // see RQ1
                                     |=> ATTN_LED == ($past(attn_mode_q) == hpl_pkg::IND_ON))
      else $error("attention lamp disagrees with command");

   chk_attn_blink: assert property (attn_mode_q == hpl_pkg::IND_BLINK // see RQ11
                                    |=> ATTN_LED == $past(blink_phase_q))
      else $error("attention lamp not following blink phase");

   chk_pwr_states: assert property (pwr_mode_q == hpl_pkg::IND_OFF && !PWR_STUCK_ON // see RQ4
                                    |=> !PWR_LED)
      else $error("power lamp lit while commanded off");

   chk_stuck_force: assert property (PWR_STUCK_ON |=> PWR_LED) // see RQ12
      else $error("stuck-on fault did not force power lamp");

   chk_ind_no_latch: assert property ($changed(latch_ok) && !ctrl_wr // see RQ10
                                      |=> $stable(attn_mode_q) && $stable(pwr_mode_q))
      else $error("indicator command moved without a write");

   chk_blink_half: assert property ($changed(blink_phase_q) // see RQ11
                                    |-> $past(blink_cnt_q) == 32'(BLINK_HALF_CYC - 1))
      else $error("blink phase toggled off the half period");

   chk_blink_bound: assert property (blink_cnt_q < 32'(BLINK_HALF_CYC)) // see RQ11
      else $error("blink counter overran the half period");

endmodule : hpl_top

//--- sim/hpl_slot_model.sv
// slot-side model: retention latch sensor with contact chatter and lamp run meter
`timescale 1ns/1ps
module hpl_slot_model (
   input  wire logic        clk,
   input  wire logic        want_closed,
   input  wire logic        chatter,
   input  wire logic [1:0]  lamps,
   output wire logic        latch_closed,
   output logic      [15:0] hi_len [2],
   output logic      [15:0] lo_len [2]
);
   logic [15:0] run_q [2] = '{default: 16'h0000};
   logic [1:0]  prev_q    = 2'h0;
   logic        flip_q    = 1'b0;

   // a lever in mid travel chatters every cycle, never a clean close
   always_ff @(posedge clk) begin
      flip_q <= ~flip_q;
   end
   assign latch_closed = chatter ? flip_q : want_closed;

   // run lengths of each lamp, so rate and duty are judged from the pins
   always_ff @(posedge clk) begin
      prev_q <= lamps;
      for (int i = 0; i < 2; i++) begin
         if (lamps[i] == prev_q[i]) begin
            run_q[i] <= run_q[i] + 16'h0001;
         end else begin
            run_q[i] <= 16'h0001;
            if (prev_q[i]) begin
               hi_len[i] <= run_q[i];
            end else begin
               lo_len[i] <= run_q[i];
            end
         end
      end
   end
endmodule : hpl_slot_model

//--- sim/test_hpl_top.sv
// self-checking bench for the slot indicator and latch block
`timescale 1ns/1ps
module test_hpl_top;
   localparam int unsigned BLINK = 8;
   localparam int unsigned DEB   = 4;
   localparam logic [7:0]  CTRL  = hpl_pkg::CTRL_OFS;
   localparam logic [7:0]  STAT  = hpl_pkg::STAT_OFS;

   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        ce = 1'b1;
   logic [7:0]  awaddr = 8'h00;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic [7:0]  araddr = 8'h00;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        stuck = 1'b0;
   logic        want_closed = 1'b1;
   logic        chatter = 1'b0;
   wire logic   awready, wready, bvalid, arready, rvalid;
   wire logic   latch, attn, pled, mpwr, aux;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   logic [15:0] hi_len [2];
   logic [15:0] lo_len [2];
   int          fail_count = 0;
   int          tests_run = 0;
   logic [31:0] rd;
   logic [1:0]  rs;

   hpl_top #(.BLINK_HALF_CYC(BLINK), .DEBOUNCE_CYC(DEB), .HAS_PWR_CTRL(1'b1)) i_hpl_top (
      .REF_CLK(clk), .SRST(srst), .CE(ce),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .LATCH_CLOSED(latch), .PWR_STUCK_ON(stuck), .ATTN_LED(attn), .PWR_LED(pled),
      .MAIN_PWR_EN(mpwr), .AUX_SW_EN(aux));

   hpl_slot_model i_hpl_slot_model (
      .clk(clk), .want_closed(want_closed), .chatter(chatter), .lamps({pled, attn}),
      .latch_closed(latch), .hi_len(hi_len), .lo_len(lo_len));

   always #25 clk = ~clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic guard(input int n);
      if (n > 40) begin
         fail_count++;
         give_verdict();
      end
   endtask : guard

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // entered just after a rising edge; readiness is judged at the falling edge,
   // where it already equals what the next rising edge samples
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      logic ah, wh, bh;
      int   n;
      n = 0;
      bh = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bh) begin
         @(negedge clk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         r = bresp;
         @(posedge clk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         n++;
         guard(n);
      end
      bready <= 1'b0;
      @(posedge clk);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ah, rh;
      int   n;
      n = 0;
      rh = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rh) begin
         @(negedge clk);
         ah = arvalid && arready;
         rh = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ah) arvalid <= 1'b0;
         n++;
         guard(n);
      end
      rready <= 1'b0;
      @(posedge clk);
   endtask : axi_rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, 4'hF, rs);
      chk(32'(rs), 32'(hpl_pkg::RESP_OKAY));
   endtask : wr

   task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
      axi_rd(a, rd, rs);
      chk(32'(rs), 32'(hpl_pkg::RESP_OKAY));
      chk(rd, exp);
   endtask : rdx

   task automatic fin(input string s);
      $display("test %s done, mismatches %0d", s, fail_count);
   endtask : fin

   function automatic logic [31:0] ctl(input logic [1:0] at, input logic [1:0] pw,
                                       input logic mp);
      return (32'(at) << hpl_pkg::CTRL_ATTN_LSB) | (32'(pw) << hpl_pkg::CTRL_PWR_LSB)
             | (32'(mp) << hpl_pkg::CTRL_MPWR_BIT);
   endfunction : ctl

   function automatic logic [31:0] st(input logic l, m, a, t, p, s);
      return (32'(l) << hpl_pkg::STAT_LATCH_BIT) | (32'(m) << hpl_pkg::STAT_MAIN_BIT)
             | (32'(a) << hpl_pkg::STAT_AUX_BIT) | (32'(t) << hpl_pkg::STAT_ATTN_BIT)
             | (32'(p) << hpl_pkg::STAT_PLED_BIT) | (32'(s) << hpl_pkg::STAT_STUCK_BIT);
   endfunction : st

   initial begin
      cyc(16);
      srst <= 1'b0;
      cyc(12);
      rdx(CTRL, 32'h0);
      rdx(STAT, st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
      fin("reset");
      // steady codes; code 3 stays dark but reads back
      for (int m = 0; m < 4; m++) begin
         if (m != 2) begin
            wr(CTRL, ctl(2'(m), 2'(m), 1'b0));
            @(negedge clk);
            chk(32'({attn, pled}), (m == 1) ? 32'h3 : 32'h0);
            @(posedge clk);
            rdx(CTRL, ctl(2'(m), 2'(m), 1'b0));
         end
      end
      fin("modes");
      wr(CTRL, ctl(hpl_pkg::IND_BLINK, hpl_pkg::IND_BLINK, 1'b0));
      cyc(5 * BLINK);
      for (int i = 0; i < 2; i++) begin
         chk(32'(hi_len[i]), 32'(BLINK));
         chk(32'(lo_len[i]), 32'(BLINK));
      end
      fin("blink");
      // latch opens under power: main and aux drop on the fourth edge, lamps stay
      wr(CTRL, ctl(hpl_pkg::IND_ON, hpl_pkg::IND_ON, 1'b1));
      cyc(2);
      want_closed <= 1'b0;
      cyc(3);
      @(negedge clk);
      chk(32'({mpwr, aux}), 32'h3);
      @(negedge clk);
      chk(32'({mpwr, aux, attn, pled}), 32'h3);
      @(posedge clk);
      rdx(STAT, st(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
      // mid travel chatter must not count as closed
      chatter <= 1'b1;
      want_closed <= 1'b1;
      cyc(20);
      rdx(STAT, st(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
      chatter <= 1'b0;
      cyc(DEB + 4);
      rdx(STAT, st(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0));
      wr(CTRL, ctl(hpl_pkg::IND_ON, hpl_pkg::IND_ON, 1'b1));
      cyc(1);
      rdx(STAT, st(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0));
      fin("latch");
      // refused or empty writes are not commands
      axi_wr(8'h40, 32'h0, 4'hF, rs);
      chk(32'(rs), 32'(hpl_pkg::RESP_SLVERR));
      axi_rd(8'h40, rd, rs);
      chk(32'(rs), 32'(hpl_pkg::RESP_SLVERR));
      chk(rd, 32'h0);
      axi_wr(CTRL, 32'h0, 4'h0, rs);
      chk(32'(rs), 32'(hpl_pkg::RESP_OKAY));
      wr(STAT, 32'h0);
      rdx(CTRL, ctl(hpl_pkg::IND_ON, hpl_pkg::IND_ON, 1'b1));
      fin("refusals");
      // platform override lights power lamp while commanded off
      wr(CTRL, ctl(hpl_pkg::IND_OFF, hpl_pkg::IND_OFF, 1'b0));
      stuck <= 1'b1;
      cyc(2);
      rdx(STAT, st(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1));
      stuck <= 1'b0;
      cyc(2);
      rdx(STAT, st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
      fin("override");
      // enable low: bus refused and lamps held, latch kept steady meanwhile
      wr(CTRL, ctl(hpl_pkg::IND_ON, hpl_pkg::IND_OFF, 1'b0));
      ce <= 1'b0;
      cyc(3);
      @(negedge clk);
      chk(32'({awready, wready, arready, attn, pled}), 32'h2);
      @(posedge clk);
      ce <= 1'b1;
      cyc(2);
      rdx(CTRL, ctl(hpl_pkg::IND_ON, hpl_pkg::IND_OFF, 1'b0));
      fin("enable");
      give_verdict();
   end
endmodule : test_hpl_top
